/* rsic_asserts.sv */
// lamp and gating relations of the indicator controller
`timescale 1ns/1ps
`default_nettype none
module rsic_asserts #(
  parameter int unsigned MS_CYCLES = 10
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // events
  input wire logic result_normal,
  input wire logic result_abnormal,
  input wire logic [3:0] port_busy,
  input wire logic [3:0] input_port,
  // lamps
  input wire logic run_lamp,
  input wire logic error_lamp,
  input wire logic [1:0] result_lamp_pair,
  input wire logic [3:0] antenna_activity_lamp,
  input wire logic [3:0] input_lamp,
  input wire logic [3:0] output_lamp,
  input wire logic [3:0] output_port,
  input wire logic [3:0] antenna_enable
);
  // pulse start may lag by one tick
  localparam int RB = MS_CYCLES + 2;
  localparam int LONG = 1501 * MS_CYCLES;
  int err_hi;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_hi <= 0;
    end else begin
      err_hi <= error_lamp ? err_hi + 1 : 0;
    end
  end
  property p_gate;
    antenna_enable != 4'h0 |=> $stable(antenna_enable);
  endproperty
  a_gate: assert property (p_gate) else $error("gating changed");
  // longer than any flash phase means halted
  property p_halt;
    err_hi > LONG |-> !run_lamp;
  endproperty
  a_halt: assert property (p_halt) else $error("run lit in halt");
  property p_norm_on;
    ce && result_normal && !result_abnormal && !error_lamp
      |-> ##[1:RB] (result_lamp_pair[0] || error_lamp);
  endproperty
  a_norm_on: assert property (p_norm_on) else $error("no green");
  property p_norm_cut;
    error_lamp [*2] |-> !result_lamp_pair[0];
  endproperty
  a_norm_cut: assert property (p_norm_cut) else $error("green kept");
  property p_abn_on;
    ce && result_abnormal && !result_normal |-> ##[1:RB] result_lamp_pair[1];
  endproperty
  a_abn_on: assert property (p_abn_on) else $error("no red");
  property p_excl;
    result_lamp_pair != 2'b11;
  endproperty
  a_excl: assert property (p_excl) else $error("both result lamps");
  // every enabled busy port must show activity one cycle later
  property p_act;
    ce |=> (antenna_activity_lamp & $past(port_busy) & $past(antenna_enable)) ==
      ($past(port_busy) & $past(antenna_enable));
  endproperty
  a_act: assert property (p_act) else $error("activity dark");
  property p_in;
    ce |=> input_lamp == $past(input_port);
  endproperty
  a_in: assert property (p_in) else $error("input lamp wrong");
  property p_out;
    output_lamp == output_port;
  endproperty
  a_out: assert property (p_out) else $error("output lamp wrong");
endmodule : rsic_asserts
bind rsic_top rsic_asserts #(.MS_CYCLES(MS_CYCLES)) chk_i (.pclk, .presetn, .ce,
  .result_normal, .result_abnormal, .port_busy, .input_port, .run_lamp, .error_lamp,
  .result_lamp_pair, .antenna_activity_lamp, .input_lamp, .output_lamp, .output_port,
  .antenna_enable);
`default_nettype wire

/* rsic_pkg.sv */
// types of the indicator block
package rsic_pkg;
  typedef enum logic [1:0] {
    RSIC_BOOT = 2'b00,
    RSIC_RUN = 2'b01,
    RSIC_HALT = 2'b10
  } rsic_state_type;
  typedef enum logic [1:0] {
    RSIC_RES_NONE = 2'b00,
    RSIC_RES_NORM = 2'b01,
    RSIC_RES_ABN = 2'b10
  } rsic_result_type;
endpackage : rsic_pkg

/* rsic_pulse.sv */
// retriggerable pulse stretcher counted in millisecond ticks
`timescale 1ns/1ps
`default_nettype none
module rsic_pulse #(
  parameter int unsigned MS = 50
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // control
  input wire logic ms_tick,
  input wire logic start,
  input wire logic kill,
  // result
  output logic active
);
  logic [15:0] left_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_r <= 16'h0000;
    end else if (ce) begin
      if (kill) begin
        left_r <= 16'h0000;
      end else if (start) begin
        left_r <= 16'(MS);
      end else if (ms_tick && left_r != 16'h0000) begin
        left_r <= left_r - 16'h0001;
      end
    end
  end
  assign active = (left_r != 16'h0000);
endmodule : rsic_pulse
`default_nettype wire

/* rsic_regs.svh */
// offsets, fields and timing counts of the indicator block
`ifndef RSIC_REGS_SVH
`define RSIC_REGS_SVH
`define RSIC_CLK_HZ 250000000
`define RSIC_MS_CYCLES (`RSIC_CLK_HZ / 1000)
`define RSIC_SELFTEST_MS 5000
`define RSIC_SHORT_ON_MS 250
`define RSIC_LONG_ON_MS 1500
`define RSIC_PULSE_MS 50
`define RSIC_OFF_CTRL 12'h000
`define RSIC_OFF_STATUS 12'h004
`define RSIC_OFF_OUTPUT 12'h008
`define RSIC_OFF_IRQ_STAT 12'h00c
`define RSIC_OFF_IRQ_CLR 12'h010
`define RSIC_OFF_IRQ_EN 12'h014
`define RSIC_CTRL_SAFE 0
`define RSIC_CTRL_NETWAIT 1
`define RSIC_CTRL_SETERR 2
`define RSIC_CTRL_SYSERR 3
`define RSIC_IRQ_NORM 0
`define RSIC_IRQ_ABN 1
`define RSIC_IRQ_SYSERR 2
`define RSIC_IRQ_READY 3
`endif

/* rsic_sense_model.sv */
// presence detectors and input sensors of the reader
`timescale 1ns/1ps
`default_nettype none
module rsic_sense_model #(
  parameter logic [3:0] PRESENT = 4'hb
) (
  // sensor levels set by the bench
  input wire logic [3:0] sense,
  // toward the controller
  output logic [3:0] antenna_present,
  output logic [3:0] input_port
);
  // cables fitted before power-up, so presence never moves
  assign antenna_present = PRESENT;
  assign input_port = sense;
endmodule : rsic_sense_model
`default_nettype wire

/* rsic_top.sv */
// status indicator and antenna gating controller of the reader
// Operation
// - sample antennas at power-on, disable absent ones
// - run lamp flashes short boot, steady, long safe
// - short flash 250 ms on, 250 off
// - long flash 1500 ms on, 1500 off
// - system error: error lamp steady, run off
// - setting error: error flashes short, run on
// - awaiting network: error lamp flashes long
// - normal result lamp 50 ms, cut by error
// - abnormal result lamp 50 ms, cut by normal
// - antenna lamp lit while its port communicates
// - detected antenna lamp pulses 50 ms once
// - input lamps follow input signals
// - output lamps follow driven outputs
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "rsic_regs.svh"
module rsic_top #(
  parameter int unsigned MS_CYCLES = `RSIC_MS_CYCLES,
  parameter int unsigned SELFTEST_MS = `RSIC_SELFTEST_MS,
  parameter int unsigned PORTS = 4
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // events and conditions
  input wire logic result_normal,
  input wire logic result_abnormal,
  input wire logic [PORTS-1:0] antenna_present,
  input wire logic [PORTS-1:0] port_busy,
  input wire logic [PORTS-1:0] input_port,
  // lamps and port gating
  output logic supply_present_lamp,
  output logic run_lamp,
  output logic error_lamp,
  output logic [1:0] result_lamp_pair,
  output logic [PORTS-1:0] antenna_activity_lamp,
  output logic [PORTS-1:0] input_lamp,
  output logic [PORTS-1:0] output_lamp,
  output logic [PORTS-1:0] output_port,
  output logic [PORTS-1:0] antenna_enable,
  output logic irq
);
  import rsic_pkg::*;

  localparam int unsigned SHORT_MS = `RSIC_SHORT_ON_MS;
  localparam int unsigned LONG_MS = `RSIC_LONG_ON_MS;

  // millisecond tick shared by every pattern so lamps flash in phase
  logic [31:0] div_r;
  logic ms_tick_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 32'h0000_0000;
      ms_tick_r <= 1'b0;
    end else if (ce) begin
      ms_tick_r <= (div_r == 32'(MS_CYCLES - 1));
      div_r <= (div_r == 32'(MS_CYCLES - 1)) ? 32'h0000_0000 : div_r + 32'h0000_0001;
    end
  end

  // flash phase generators
  logic [15:0] short_cnt_r;
  logic [15:0] long_cnt_r;
  logic short_on_r;
  logic long_on_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      short_cnt_r <= 16'h0000;
      short_on_r <= 1'b1;
    end else if (ce && ms_tick_r) begin
      if (short_cnt_r == 16'(SHORT_MS - 1)) begin
        short_cnt_r <= 16'h0000;
        short_on_r <= ~short_on_r;
      end else begin
        short_cnt_r <= short_cnt_r + 16'h0001;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      long_cnt_r <= 16'h0000;
      long_on_r <= 1'b1;
    end else if (ce && ms_tick_r) begin
      if (long_cnt_r == 16'(LONG_MS - 1)) begin
        long_cnt_r <= 16'h0000;
        long_on_r <= ~long_on_r;
      end else begin
        long_cnt_r <= long_cnt_r + 16'h0001;
      end
    end
  end

  // control register written by software
  logic [3:0] ctrl_r;
  logic [PORTS-1:0] out_r;
  logic [3:0] irq_stat_r;
  logic [3:0] irq_en_r;
  logic wr_en;
  logic rd_en;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  // boot sequence state
  rsic_state_type state_r;
  logic [15:0] boot_ms_r;
  logic boot_done;
  assign boot_done = (state_r == RSIC_BOOT) && ms_tick_r &&
                     (boot_ms_r == 16'(SELFTEST_MS - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= RSIC_BOOT;
      boot_ms_r <= 16'h0000;
    end else if (ce) begin
      unique case (state_r)
        RSIC_BOOT: begin
          if (ctrl_r[`RSIC_CTRL_SYSERR]) begin
            state_r <= RSIC_HALT;
          end else if (boot_done) begin
            state_r <= RSIC_RUN;
          end else if (ms_tick_r) begin
            boot_ms_r <= boot_ms_r + 16'h0001;
          end
        end
        RSIC_RUN: begin
          if (ctrl_r[`RSIC_CTRL_SYSERR]) begin
            state_r <= RSIC_HALT;
          end
        end
        RSIC_HALT: begin
          // only a reset leaves the halt
          state_r <= RSIC_HALT;
        end
        default: begin
          state_r <= RSIC_HALT;
        end
      endcase
    end
  end

  // antenna presence caught once, one cycle after reset release
  logic sampled_r;
  logic [PORTS-1:0] ant_en_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sampled_r <= 1'b0;
      ant_en_r <= '0;
    end else if (ce && !sampled_r) begin
      sampled_r <= 1'b1;
      ant_en_r <= antenna_present;
    end
  end

  // result lamp pulses; a fresh normal result cuts the abnormal one and
  // the error lamp cuts the normal one
  logic norm_act;
  logic abn_act;
  logic err_lit;
  rsic_pulse #(.MS(`RSIC_PULSE_MS)) u_norm (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .ms_tick(ms_tick_r),
    .start(result_normal),
    .kill(err_lit),
    .active(norm_act)
  );
  rsic_pulse #(.MS(`RSIC_PULSE_MS)) u_abn (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .ms_tick(ms_tick_r),
    .start(result_abnormal && !result_normal),
    .kill(result_normal),
    .active(abn_act)
  );

  // one detection pulse per present antenna
  logic [PORTS-1:0] det_act;
  genvar g;
  generate
    for (g = 0; g < PORTS; g++) begin : g_det
      rsic_pulse #(.MS(`RSIC_PULSE_MS)) u_det (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .ms_tick(ms_tick_r),
        .start(!sampled_r && antenna_present[g]),
        .kill(1'b0),
        .active(det_act[g])
      );
    end
  endgenerate

  // error lamp drive with priority: system, setting, network wait
  always_comb begin
    if (state_r == RSIC_HALT) begin
      err_lit = 1'b1;
    end else if (ctrl_r[`RSIC_CTRL_SETERR]) begin
      err_lit = short_on_r;
    end else if (ctrl_r[`RSIC_CTRL_NETWAIT]) begin
      err_lit = long_on_r;
    end else begin
      err_lit = 1'b0;
    end
  end

  // lamp registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_present_lamp <= 1'b0;
      run_lamp <= 1'b0;
      error_lamp <= 1'b0;
      result_lamp_pair <= 2'b00;
    end else if (ce) begin
      supply_present_lamp <= 1'b1;
      error_lamp <= err_lit;
      unique case (state_r)
        RSIC_BOOT: run_lamp <= short_on_r;
        RSIC_RUN: run_lamp <= ctrl_r[`RSIC_CTRL_SAFE] ? long_on_r : 1'b1;
        RSIC_HALT: run_lamp <= 1'b0;
        default: run_lamp <= 1'b0;
      endcase
      result_lamp_pair <= {abn_act && !norm_act, norm_act && !err_lit};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      antenna_activity_lamp <= '0;
      input_lamp <= '0;
      output_lamp <= '0;
      output_port <= '0;
      antenna_enable <= '0;
    end else if (ce) begin
      antenna_activity_lamp <= (port_busy & ant_en_r) | det_act;
      input_lamp <= input_port;
      output_lamp <= out_r;
      output_port <= out_r;
      antenna_enable <= ant_en_r;
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 4'h0;
      out_r <= '0;
      irq_en_r <= 4'h0;
    end else if (ce && wr_en) begin
      unique case (paddr)
        `RSIC_OFF_CTRL: ctrl_r <= pwdata[3:0];
        `RSIC_OFF_OUTPUT: out_r <= pwdata[PORTS-1:0];
        `RSIC_OFF_IRQ_EN: irq_en_r <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // sticky events; a new event wins over a clear in the same cycle
  logic [3:0] irq_set;
  logic [3:0] irq_clr;
  assign irq_set = {boot_done, state_r != RSIC_HALT && ctrl_r[`RSIC_CTRL_SYSERR],
                    result_abnormal, result_normal};
  assign irq_clr = (wr_en && paddr == `RSIC_OFF_IRQ_CLR) ? pwdata[3:0] : 4'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= 4'h0;
      irq <= 1'b0;
    end else if (ce) begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
      irq <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_en_r);
    end
  end

  // apb answer: zero wait states, unmapped addresses read zero with error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable) begin
        unique case (paddr)
          `RSIC_OFF_CTRL: prdata <= {28'h0000000, ctrl_r};
          `RSIC_OFF_STATUS: prdata <= {22'h000000, state_r, 4'(ant_en_r), 4'(input_port)};
          `RSIC_OFF_OUTPUT: prdata <= {28'h0000000, 4'(out_r)};
          `RSIC_OFF_IRQ_STAT: prdata <= {28'h0000000, irq_stat_r};
          `RSIC_OFF_IRQ_CLR: prdata <= 32'h0000_0000;
          `RSIC_OFF_IRQ_EN: prdata <= {28'h0000000, irq_en_r};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
  logic unused_rd;
  assign unused_rd = rd_en;
endmodule : rsic_top
`default_nettype wire

/* rsic_top_tb_top.sv */
// bench of the indicator controller
`timescale 1ns/1ps
`default_nettype none
`include "rsic_regs.svh"
module rsic_top_tb_top;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, serr, irq;
  logic result_normal, result_abnormal, supply_present_lamp, run_lamp, error_lamp;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] result_lamp_pair;
  logic [3:0] port_busy, sense, antenna_present, input_port, antenna_activity_lamp;
  logic [3:0] input_lamp, output_lamp, output_port, antenna_enable;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int n;
  rsic_top #(.MS_CYCLES(10), .SELFTEST_MS(600)) dut (.pclk, .presetn, .ce, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .result_normal,
    .result_abnormal, .antenna_present, .port_busy, .input_port, .supply_present_lamp,
    .run_lamp, .error_lamp, .result_lamp_pair, .antenna_activity_lamp, .input_lamp,
    .output_lamp, .output_port, .antenna_enable, .irq);
  rsic_sense_model far (.sense, .antenna_present, .input_port);
  task automatic final_report();
    $display("checks %0d bad %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // holds the request until pready, then two idle edges
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : apb
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk("rd", e, rd);
  endtask : rdc
  task automatic pls(input logic nrm);
    if (nrm) result_normal <= 1'b1;
    else result_abnormal <= 1'b1;
    @(posedge pclk);
    result_normal <= 1'b0;
    result_abnormal <= 1'b0;
  endtask : pls
  task automatic wt(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 40000) begin
      @(posedge pclk);
      n++;
    end
    // a wait that runs out is a mismatch, not a silent pass
    if (s !== v) begin
      bad_count++;
      $display("BAD wait exp %h got %h", v, s);
    end
  endtask : wt
  initial begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, result_normal, result_abnormal} = '0;
    {paddr, pwdata, port_busy} = '0;
    ce = 1;
    sense = 4'h5;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (30) @(posedge pclk);
    chk("det", 4'hb, antenna_activity_lamp);
    chk("pwr", 1, supply_present_lamp);
    rdc(`RSIC_OFF_STATUS, 32'h0b5);
    wt(run_lamp, 0);
    chk("det_end", 0, antenna_activity_lamp);
    wt(run_lamp, 1);
    chk("boot_off", 1, n > 2498 && n < 2502);
    repeat (2500) @(posedge pclk);
    chk("steady", 1, run_lamp);
    rdc(`RSIC_OFF_STATUS, 32'h1b5);
    rdc(`RSIC_OFF_IRQ_STAT, 32'h8);
    apb(1, `RSIC_OFF_IRQ_EN, 32'h8);
    chk("irq", 1, irq);
    apb(1, `RSIC_OFF_IRQ_CLR, 32'h8);
    chk("irq_clr", 0, irq);
    apb(1, `RSIC_OFF_IRQ_EN, 32'h0);
    apb(1, `RSIC_OFF_OUTPUT, 32'ha);
    chk("out", 4'ha, output_port);
    rdc(`RSIC_OFF_OUTPUT, 32'ha);
    sense <= 4'h6;
    port_busy <= 4'hf;
    repeat (3) @(posedge pclk);
    chk("in", 4'h6, input_lamp);
    chk("act", 4'hb, antenna_activity_lamp);
    port_busy <= 4'h0;
    pls(0);
    repeat (30) @(posedge pclk);
    chk("abn", 2'b10, result_lamp_pair);
    pls(1);
    repeat (30) @(posedge pclk);
    chk("norm", 2'b01, result_lamp_pair);
    repeat (500) @(posedge pclk);
    chk("res_end", 0, result_lamp_pair);
    chk("masked", 0, irq);
    rdc(`RSIC_OFF_IRQ_STAT, 32'h3);
    apb(1, `RSIC_OFF_CTRL, 32'h4);
    wt(error_lamp, 1);
    pls(1);
    repeat (30) @(posedge pclk);
    chk("norm_cut", 0, result_lamp_pair[0]);
    chk("run_on", 1, run_lamp);
    wt(error_lamp, 0);
    wt(error_lamp, 1);
    chk("err_off", 1, n > 2498 && n < 2502);
    apb(1, `RSIC_OFF_CTRL, 32'h3);
    wt(error_lamp, 1);
    wt(error_lamp, 0);
    chk("phase0", 0, run_lamp);
    wt(error_lamp, 1);
    chk("phase1", 1, run_lamp);
    wt(error_lamp, 0);
    chk("long_on", 1, n > 14998 && n < 15002);
    apb(0, 12'h020, 0);
    chk("slverr", 1, serr);
    chk("unmapped", 0, rd);
    apb(1, `RSIC_OFF_CTRL, 32'h8);
    repeat (15100) @(posedge pclk);
    chk("halt_err", 1, error_lamp);
    chk("halt_run", 0, run_lamp);
    rdc(`RSIC_OFF_STATUS, 32'h2b6);
    rdc(`RSIC_OFF_IRQ_STAT, 32'h7);
    final_report();
  end
endmodule : rsic_top_tb_top
`default_nettype wire
